/* core/bthd_top.sv */
// Host-side signals: interrupts, timers, strobes, biphase pins, DMA
// Behaviour
// [R1] Standard level set on any enabled event
// [R2] Standard level holds until host clears it
// [R3] Standard pulse on each logged entry
// [R4] High-priority level set on enabled events
// [R5] High-priority level released only by bit resets
// [R6] RT transmit starts 760 us fail-safe timer
// [R7] New RT command resets the fail-safe timer
// [R8] Command strobe from valid command to serviced
// [R9] Self-test fail output, RT terminal flag
// [R10] Channel indicator shows active or last channel
// [R11] Both transmit lines low while channel idle
// [R12] Receive takes true and complement pairs
// [R13] Request raised for RAM, dropped after grant
// [R14] Grant sampled at half-clock rising edge
// [R15] Unneeded grant passes to grant out
// [R16] Acknowledge low from grant until access done
// [R17] Burst flag for two or more words
// [R18] Tristate control exactly while driving buses
// [R19] Host floats its buses while tristate active
// [R20] Half-rate memory clock from memory clock
// [R21] Memory cycle lasts two memory clocks
// [R22] Strobes after grant, one pulse per word
// [R23] True and complement never high together
`include "bthd_cfg.svh"
module bthd_top #(
  // Fail-safe window in core clocks, shorten for simulation
  parameter int unsigned TIMER_CYCLES =
    `BTHD_FAILSAFE_US * `BTHD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Pins from outside the clock domain
  input  wire logic                  mem_clock_pin,
  input  wire logic                  mem_grant_n,
  input  wire logic                  rx_chan_a_true,
  input  wire logic                  rx_chan_a_comp,
  input  wire logic                  rx_chan_b_true,
  input  wire logic                  rx_chan_b_comp,
  // Core: interrupt events
  input  wire logic [`BTHD_STD_W-1:0] std_events,
  input  wire logic [`BTHD_STD_W-1:0] std_enable,
  input  wire logic                  std_clear,
  input  wire logic                  log_entry,
  input  wire logic [`BTHD_HP_W-1:0]  hp_events,
  input  wire logic [`BTHD_HP_W-1:0]  hp_enable,
  input  wire logic [`BTHD_HP_W-1:0]  hp_clear,
  // Core: terminal state
  input  wire logic                  rt_mode,
  input  wire logic                  tx_start,
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_done,
  input  wire logic                  bit_fail,
  input  wire logic                  chan_act,
  input  wire logic                  chan_act_a,
  input  wire logic [1:0]            tx_en,
  input  wire logic [1:0]            tx_bit,
  // Core: memory request
  input  wire logic                  mem_need,
  input  wire logic                  mem_write,
  input  wire logic [`BTHD_WCNT_W-1:0] mem_words,
  // Core: answers
  output logic [3:0]                 rx_pairs,
  output logic                       mem_busy,
  output logic                       mem_done,
  output logic                       terminal_flag,
  // Interrupt and status pins
  output logic                       standard_irq_level_n,
  output logic                       standard_irq_pulse_n,
  output logic                       high_priority_irq_n,
  output logic                       tx_failsafe_timer_n,
  output logic                       valid_command_strobe_n,
  output logic                       self_test_fail,
  output logic                       channel_indicator,
  // Biphase transmit pins
  output logic                       tx_chan_a_true,
  output logic                       tx_chan_a_comp,
  output logic                       tx_chan_b_true,
  output logic                       tx_chan_b_comp,
  // DMA pins
  output logic                       mem_request_n,
  output logic                       grant_passthrough_n,
  output logic                       mem_acknowledge_n,
  output logic                       burst,
  output logic                       tristate_control_n,
  output logic                       memory_clock_half,
  output logic                       ram_read_strobe_n,
  output logic                       ram_write_strobe_n
);
  import bthd_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [`BTHD_NSYNC-1:0] pin_raw;  // Raw pin levels
  logic [`BTHD_NSYNC-1:0] sync1_q;  // First stage, read by stage two only
  logic [`BTHD_NSYNC-1:0] sync2_q;  // Settled levels
  logic                   mclk_prev_q; // Memory clock last cycle
  logic                   mclk_rise;   // Memory clock rising edge

  assign pin_raw = {mem_clock_pin, mem_grant_n, rx_chan_b_comp,
                    rx_chan_b_true, rx_chan_a_comp, rx_chan_a_true};

  // Two flops per pin against metastability
  for (genvar i = 0; i < `BTHD_NSYNC; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        sync1_q[i] <= 1'(`BTHD_SYNC_RST >> i);
        sync2_q[i] <= 1'(`BTHD_SYNC_RST >> i);
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // Edge detect on the settled memory clock
  always_ff @(posedge clock) begin
    if (rst) begin
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= sync2_q[5];
    end
  end
  assign mclk_rise = sync2_q[5] & ~mclk_prev_q;
  // Receive pairs handed on as true/complement per channel
  assign rx_pairs  = sync2_q[3:0]; // R12

  // ****************************************
  // Interrupt outputs
  // ****************************************
  logic                  std_q, std_d;   // Standard level held
  logic                  stp_q, stp_d;   // Standard pulse, active low
  logic [`BTHD_HP_W-1:0] hps_q, hps_d;   // High-priority status
  logic                  hpl_q, hpl_d;   // High-priority pin, active low
  logic                  std_set;        // Any enabled standard event

  assign std_set = |(std_events & std_enable);

  // Set wins over a clear in the same cycle
  always_comb begin
    std_d = std_q;
    if (std_clear) begin
      std_d = 1'b0; // R2
    end
    if (std_set) begin
      std_d = 1'b1; // R1
    end
    stp_d = ~log_entry; // R3
    hps_d = (hps_q & ~hp_clear) | (hp_events & hp_enable); // R4 R5
    hpl_d = ~|hps_d; // R5
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      std_q <= 1'b0;
      stp_q <= 1'b1;
      hps_q <= '0;
      hpl_q <= 1'b1;
    end else begin
      std_q <= std_d;
      stp_q <= stp_d;
      hps_q <= hps_d;
      hpl_q <= hpl_d;
    end
  end

  assign standard_irq_level_n = ~std_q;
  assign standard_irq_pulse_n = stp_q;
  assign high_priority_irq_n  = hpl_q;

  // ****************************************
  // Fail-safe timer and command strobe
  // ****************************************
  localparam bthd_tmr_t TMR_LAST = bthd_tmr_t'(TIMER_CYCLES - 1);
  bthd_tmr_t tmr_q, tmr_d;   // Cycles since transmit start
  logic      ton_q, ton_d;   // Timer running
  logic      cst_q, cst_d;   // Command being serviced

  // A start in the same cycle as a command keeps the timer on
  always_comb begin
    tmr_d = tmr_q;
    ton_d = ton_q;
    cst_d = cst_q;
    if (!rt_mode) begin
      ton_d = 1'b0;
      cst_d = 1'b0;
    end else begin
      if (ton_q) begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == TMR_LAST) begin
          ton_d = 1'b0; // R6
        end
      end
      if (cmd_valid) begin
        ton_d = 1'b0; // R7
      end
      if (tx_start) begin
        ton_d = 1'b1; // R6
        tmr_d = '0;
      end
      if (cmd_done) begin
        cst_d = 1'b0; // R8
      end
      if (cmd_valid) begin
        cst_d = 1'b1; // R8
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tmr_q <= '0;
      ton_q <= 1'b0;
      cst_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      ton_q <= ton_d;
      cst_q <= cst_d;
    end
  end

  assign tx_failsafe_timer_n    = ~ton_q;
  assign valid_command_strobe_n = ~cst_q;

  // ****************************************
  // Fail, channel and transmit pins
  // ****************************************
  logic       flt_q, flt_d;  // Self-test failure seen
  logic       tfl_q, tfl_d;  // Terminal flag for status word
  logic       cha_q, cha_d;  // High for channel A
  logic [3:0] txp_q, txp_d;  // {b_comp, b_true, a_comp, a_true}

  always_comb begin
    flt_d = bit_fail; // R9
    tfl_d = bit_fail & rt_mode; // R9
    // Last active channel kept when the bus goes quiet
    cha_d = chan_act ? chan_act_a : cha_q; // R10
    // Gating by enable keeps idle low and the pair exclusive
    txp_d = {tx_en[1] & ~tx_bit[1], tx_en[1] & tx_bit[1],
             tx_en[0] & ~tx_bit[0], tx_en[0] & tx_bit[0]}; // R11 R23
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flt_q <= 1'b0;
      tfl_q <= 1'b0;
      cha_q <= 1'b1;
      txp_q <= '0;
    end else begin
      flt_q <= flt_d;
      tfl_q <= tfl_d;
      cha_q <= cha_d;
      txp_q <= txp_d;
    end
  end

  assign self_test_fail    = flt_q;
  assign terminal_flag     = tfl_q;
  assign channel_indicator = cha_q;
  assign tx_chan_a_true    = txp_q[0];
  assign tx_chan_a_comp    = txp_q[1];
  assign tx_chan_b_true    = txp_q[2];
  assign tx_chan_b_comp    = txp_q[3];

  // ****************************************
  // DMA engine
  // ****************************************
  bthd_mem_if mif ();

  assign mif.need  = mem_need;
  assign mif.write = mem_write;
  assign mif.words = mem_words;
  assign mem_busy  = mif.busy;
  assign mem_done  = mif.done;

  // Host must float its buses while tristate is low
  bthd_dma u_dma ( // R19
    .clock               (clock),
    .rst                 (rst),
    .mclk_rise           (mclk_rise),
    .grant_n_s           (sync2_q[4]),
    .mem                 (mif.eng),
    .memory_clock_half   (memory_clock_half),
    .mem_request_n       (mem_request_n),
    .mem_acknowledge_n   (mem_acknowledge_n),
    .grant_passthrough_n (grant_passthrough_n),
    .burst               (burst),
    .tristate_control_n  (tristate_control_n),
    .ram_read_strobe_n   (ram_read_strobe_n),
    .ram_write_strobe_n  (ram_write_strobe_n)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_STD_SET: assert property (std_set |=> !standard_irq_level_n) // R1
    else $error("standard level not raised");
  AST_STD_HOLD: assert property ( // R2
    !standard_irq_level_n && !std_clear |=> !standard_irq_level_n)
    else $error("standard level dropped without clear");
  AST_STD_PULSE: assert property ( // R3
    log_entry |=> !standard_irq_pulse_n)
    else $error("no pulse for logged entry");
  AST_HP_SET: assert property ( // R4
    |(hp_events & hp_enable) |=> !high_priority_irq_n)
    else $error("high-priority level not raised");
  AST_HP_HOLD: assert property ( // R5
    !high_priority_irq_n && hp_clear == '0 |=> !high_priority_irq_n)
    else $error("high-priority level dropped without reset");
  AST_TMR_START: assert property ( // R6
    rt_mode && tx_start |=> !tx_failsafe_timer_n)
    else $error("fail-safe timer not started");
  AST_TMR_END: assert property ( // R6
    ton_q && tmr_q == TMR_LAST && !tx_start |=> tx_failsafe_timer_n)
    else $error("fail-safe timer overran");
  AST_TMR_CMD: assert property ( // R7
    rt_mode && cmd_valid && !tx_start |=> tx_failsafe_timer_n)
    else $error("timer not reset by command");
  AST_CMD_STB: assert property ( // R8
    rt_mode && cmd_valid |=> !valid_command_strobe_n)
    else $error("command strobe missing");
  AST_FAIL: assert property ( // R9
    bit_fail && rt_mode |=> self_test_fail && terminal_flag)
    else $error("fail not flagged");
  AST_TX_EXCL: assert property ( // R23
    !(tx_chan_a_true && tx_chan_a_comp) &&
    !(tx_chan_b_true && tx_chan_b_comp))
    else $error("transmit pair both high");
  AST_TX_IDLE: assert property ( // R11
    !tx_en[0] |=> !tx_chan_a_true && !tx_chan_a_comp)
    else $error("idle channel A not low");
  CV_STD_CLR: cover property (!standard_irq_level_n ##1 std_clear);
  CV_TMR_RUN: cover property (tx_start ##[1:40] cmd_valid);
endmodule

/* core/bthd_cfg.svh */
// Constants for the bus terminal host-side signal block
`ifndef BTHD_CFG_SVH
`define BTHD_CFG_SVH
// Core clock rate in MHz (5 ns period)
`define BTHD_CLK_MHZ 200
// Fail-safe transmitter window in microseconds
`define BTHD_FAILSAFE_US 760
// Width of the fail-safe counter
`define BTHD_TMR_W 18
// Synchronised pins: mclk, grant, four receive lines
`define BTHD_NSYNC 6
// Reset pattern of the synchronisers (grant idles high)
`define BTHD_SYNC_RST 6'h10
// Interrupt event widths
`define BTHD_STD_W 8
`define BTHD_HP_W 8
// DMA word count width and burst limits
`define BTHD_WCNT_W 3
`define BTHD_WORDS_MIN 3'h1
`define BTHD_BURST_MIN 3'h2
`define BTHD_BURST_MAX 3'h6
`endif

/* core/bthd_pkg.sv */
// Types shared by the bus terminal host-side signal block
`include "bthd_cfg.svh"
package bthd_pkg;
  // DMA handshake states
  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_REQ,
    DMA_XFER
  } bthd_dma_st_t;
  // Fail-safe counter value
  typedef logic [`BTHD_TMR_W-1:0] bthd_tmr_t;
  // DMA word count
  typedef logic [`BTHD_WCNT_W-1:0] bthd_wcnt_t;
endpackage

/* core/bthd_mem_if.sv */
// Request and answer bundle between core logic and the DMA engine
interface bthd_mem_if;
  import bthd_pkg::*;
  logic       need;   // Core wants a RAM access
  logic       write;  // Access direction, high for write
  bthd_wcnt_t words;  // Words in this cycle, dummy included
  logic       busy;   // Engine owns or waits for the RAM
  logic       done;   // One-cycle pulse when access ends
  modport core (output need, output write, output words,
                input busy, input done);
  modport eng  (input need, input write, input words,
                output busy, output done);
endinterface

/* core/bthd_dma.sv */
// DMA request, grant, acknowledge and strobe engine
`include "bthd_cfg.svh"
module bthd_dma (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Memory clock rising edge, grant after synchronisers
  input  wire logic mclk_rise,
  input  wire logic grant_n_s,
  // Core request side
  bthd_mem_if.eng   mem,
  // Pins
  output logic      memory_clock_half,
  output logic      mem_request_n,
  output logic      mem_acknowledge_n,
  output logic      grant_passthrough_n,
  output logic      burst,
  output logic      tristate_control_n,
  output logic      ram_read_strobe_n,
  output logic      ram_write_strobe_n
);
  import bthd_pkg::*;

  // ****************************************
  // State
  // ****************************************
  bthd_dma_st_t st_q, st_d;       // Handshake state
  bthd_wcnt_t   left_q, left_d;   // Words still to move
  logic         half_q, half_d;   // Half-rate memory clock
  logic         wr_q, wr_d;       // Direction of this access
  logic         req_q, req_d;     // Request pin, active low
  logic         ack_q, ack_d;     // Acknowledge pin, active low
  logic         gpo_q, gpo_d;     // Grant out pin, active low
  logic         bst_q, bst_d;     // Burst pin
  logic         rd_q, rd_d;       // Read strobe, active low
  logic         wrs_q, wrs_d;     // Write strobe, active low
  logic         done_q, done_d;   // Access finished pulse
  logic         busy_q, busy_d;   // Engine not idle, registered
  logic         half_rise;        // Memory cycle boundary
  logic         half_fall;        // Middle of a memory cycle
  logic         grant;            // Grant present
  bthd_wcnt_t   words;            // Clamped word count

  assign half_rise = mclk_rise & ~half_q;
  assign half_fall = mclk_rise & half_q;
  assign grant     = ~grant_n_s;

  // Count clamp: zero means one word, never past five plus dummy
  always_comb begin
    if (mem.words < `BTHD_WORDS_MIN) begin
      words = `BTHD_WORDS_MIN;
    end else if (mem.words > `BTHD_BURST_MAX) begin
      words = `BTHD_BURST_MAX; // R17
    end else begin
      words = mem.words;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    wr_d   = wr_q;
    req_d  = req_q;
    ack_d  = ack_q;
    bst_d  = bst_q;
    rd_d   = rd_q;
    wrs_d  = wrs_q;
    done_d = 1'b0;
    half_d = mclk_rise ? ~half_q : half_q; // R20
    // Unused grant goes on down the chain
    gpo_d  = ~(grant & (st_q == DMA_IDLE) & ~mem.need); // R15
    unique case (st_q)
      DMA_IDLE: begin
        if (mem.need) begin
          req_d  = 1'b0; // R13
          left_d = words;
          wr_d   = mem.write;
          st_d   = DMA_REQ;
        end
      end
      DMA_REQ: begin
        // Grant only counts at a half-clock rising edge
        if (half_rise && grant) begin // R14
          req_d = 1'b1; // R13
          ack_d = 1'b0; // R16
          bst_d = (left_q >= `BTHD_BURST_MIN); // R17
          rd_d  = wr_q;  // R22
          wrs_d = ~wr_q; // R22
          st_d  = DMA_XFER;
        end
      end
      DMA_XFER: begin
        // One word per two memory clocks, strobe in first half
        if (half_fall) begin // R21
          rd_d  = 1'b1;
          wrs_d = 1'b1;
        end
        if (half_rise) begin
          left_d = left_q - 1'b1;
          if (left_q == `BTHD_WORDS_MIN) begin
            ack_d  = 1'b1; // R16
            bst_d  = 1'b0;
            done_d = 1'b1;
            st_d   = DMA_IDLE;
          end else begin
            rd_d  = wr_q;  // R22
            wrs_d = ~wr_q; // R22
          end
        end
      end
      default: st_d = DMA_IDLE;
    endcase
    // Busy follows the next state so the pin comes from a flop
    busy_d = (st_d != DMA_IDLE);
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q   <= DMA_IDLE;
      left_q <= '0;
      half_q <= 1'b0;
      wr_q   <= 1'b0;
      req_q  <= 1'b1;
      ack_q  <= 1'b1;
      gpo_q  <= 1'b1;
      bst_q  <= 1'b0;
      rd_q   <= 1'b1;
      wrs_q  <= 1'b1;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      left_q <= left_d;
      half_q <= half_d;
      wr_q   <= wr_d;
      req_q  <= req_d;
      ack_q  <= ack_d;
      gpo_q  <= gpo_d;
      bst_q  <= bst_d;
      rd_q   <= rd_d;
      wrs_q  <= wrs_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign memory_clock_half   = half_q;
  assign mem_request_n       = req_q;
  assign mem_acknowledge_n   = ack_q;
  assign grant_passthrough_n = gpo_q;
  assign burst               = bst_q;
  // Buses are driven exactly while acknowledged
  assign tristate_control_n  = ack_q; // R18
  assign ram_read_strobe_n   = rd_q;
  assign ram_write_strobe_n  = wrs_q;
  assign mem.busy            = busy_q;
  assign mem.done            = done_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] nstb_q; // Strobes seen in this acknowledge
  // Cleared only between accesses, so the first strobe counts too
  always_ff @(posedge clock) begin
    if (rst || (ack_q && ack_d)) begin
      nstb_q <= '0;
    end else if (!(rd_d & wrs_d) && (rd_q & wrs_q)) begin
      nstb_q <= nstb_q + 1'b1;
    end
  end
  AST_REQ_DROP: assert property ( // R13
    (st_q == DMA_REQ) && half_rise && grant |=> mem_request_n)
    else $error("request not released after grant");
  AST_STB_GRANT: assert property ( // R22
    !(ram_read_strobe_n & ram_write_strobe_n) |-> !mem_acknowledge_n)
    else $error("strobe outside acknowledged access");
  AST_BURST_MAX: assert property (nstb_q <= `BTHD_BURST_MAX) // R17
    else $error("burst longer than six words");
  AST_HALF_DIV: assert property ( // R20
    mclk_rise |=> memory_clock_half != $past(memory_clock_half))
    else $error("half clock did not toggle");
  AST_GPO_IDLE: assert property ( // R15
    !grant_passthrough_n |-> mem_request_n && mem_acknowledge_n)
    else $error("grant passed on while in use");
  AST_TS_ACK: assert property ( // R18
    $fell(mem_acknowledge_n) |-> !tristate_control_n && mem_request_n)
    else $error("bus drive not matching acknowledge");
  CV_BURST: cover property (burst ##[1:200] $rose(mem_acknowledge_n));
  CV_GPO: cover property ($fell(grant_passthrough_n));
endmodule

/* tb/bthd_arb_model.sv */
// Host-side DMA arbiter model: memory clock and grant
module bthd_arb_model #(
  parameter int MCLK_HALF = 4, // Core cycles per memory clock half
  parameter int GNT_DLY   = 3  // Arbiter latency before granting
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Engine pins
  input  wire logic mem_request_n,
  input  wire logic mem_acknowledge_n,
  input  wire logic tristate_control_n,
  // Bench command: grant nobody asked for
  input  wire logic stray,
  // Arbiter pins
  output logic      mem_clock_pin,
  output logic      mem_grant_n,
  output logic      host_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;        // Memory clock phase counter
  int wait_q = 0;     // Cycles since request seen
  // Free-running memory clock, slower than the core clock
  always @(posedge clock) begin
    cnt <= (cnt == MCLK_HALF - 1) ? 0 : cnt + 1;
    if (rst)
      mem_clock_pin <= 1'b0;
    else if (cnt == MCLK_HALF - 1)
      mem_clock_pin <= ~mem_clock_pin;
  end
  // Grant held across memory clock edges until acknowledged
  always @(posedge clock) begin
    if (rst || !mem_acknowledge_n) begin
      wait_q <= 0;
      mem_grant_n <= 1'b1;
    end else if (!mem_request_n || stray) begin
      wait_q <= wait_q + 1;
      if (wait_q >= GNT_DLY)
        mem_grant_n <= 1'b0;
    end else begin
      wait_q <= 0;
      mem_grant_n <= 1'b1;
    end
  end
  // Host drives its buses only while the engine floats them
  assign host_drive = tristate_control_n;
endmodule

/* tb/tb.sv */
// Self-checking bench for the host-side signal block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMR = 20; // Short fail-safe window for simulation
  // Stimulus
  logic clock = 0, rst = 1, stray = 0;
  logic rx_chan_a_true = 0, rx_chan_a_comp = 0;
  logic rx_chan_b_true = 0, rx_chan_b_comp = 0;
  logic [7:0] std_events = 0, std_enable = 0;
  logic [7:0] hp_events = 0, hp_enable = 0, hp_clear = 0;
  logic std_clear = 0, log_entry = 0, rt_mode = 0, tx_start = 0;
  logic cmd_valid = 0, cmd_done = 0, bit_fail = 0, chan_act = 0;
  logic chan_act_a = 0, mem_need = 0, mem_write = 0;
  logic [1:0] tx_en = 0, tx_bit = 0;
  logic [2:0] mem_words = 1;
  // Observed
  logic [3:0] rx_pairs;
  logic mem_clock_pin, mem_grant_n, host_drive, mem_busy, mem_done;
  logic terminal_flag, standard_irq_level_n, standard_irq_pulse_n;
  logic high_priority_irq_n, tx_failsafe_timer_n, valid_command_strobe_n;
  logic self_test_fail, channel_indicator, tx_chan_a_true, tx_chan_a_comp;
  logic tx_chan_b_true, tx_chan_b_comp, mem_request_n, grant_passthrough_n;
  logic mem_acknowledge_n, burst, tristate_control_n, memory_clock_half;
  logic ram_read_strobe_n, ram_write_strobe_n;
  int fail_count = 0, checks = 0, cyc = 0;
  bthd_top #(.TIMER_CYCLES(TMR)) DUT (.*);
  bthd_arb_model ARB (.*);
  always #2.5 clock = ~clock;
  // Compare one value, report and count a mismatch
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: far above the sum of all scenarios
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end
  // Interrupt levels, pulse and per-bit release
  task automatic t_irq;
    tk(1); std_enable <= 8'h04; std_events <= 8'h02;
    tk(2); #1 chk("std_masked", standard_irq_level_n, 1);
    tk(1); std_events <= 8'h06;
    tk(1); std_events <= 0;
    #1 chk("std_set", standard_irq_level_n, 0);
    tk(4); #1 chk("std_hold", standard_irq_level_n, 0);
    tk(1); std_clear <= 1;
    tk(1); std_clear <= 0;
    #1 chk("std_clr", standard_irq_level_n, 1);
    tk(1); log_entry <= 1;
    tk(1); log_entry <= 0;
    #1 chk("pulse_on", standard_irq_pulse_n, 0);
    tk(1); #1 chk("pulse_off", standard_irq_pulse_n, 1);
    tk(1); hp_enable <= 8'h81; hp_events <= 8'h80;
    tk(1); hp_events <= 0;
    #1 chk("hp_set", high_priority_irq_n, 0);
    tk(1); hp_clear <= 8'h01;
    tk(1); hp_clear <= 8'h80;
    #1 chk("hp_other", high_priority_irq_n, 0);
    tk(1); hp_clear <= 0;
    #1 chk("hp_clr", high_priority_irq_n, 1);
    $display("irq test done");
  endtask
  // Fail-safe timer expiry, stop by command, command strobe
  task automatic t_tmr;
    tk(1); rt_mode <= 1; tx_start <= 1;
    tk(1); tx_start <= 0;
    #1 chk("tmr_on", tx_failsafe_timer_n, 0);
    tk(TMR - 1); #1 chk("tmr_run", tx_failsafe_timer_n, 0);
    tk(1); #1 chk("tmr_end", tx_failsafe_timer_n, 1);
    tk(1); tx_start <= 1;
    tk(1); tx_start <= 0;
    tk(3); cmd_valid <= 1;
    tk(1); cmd_valid <= 0;
    #1 chk("tmr_cmd", tx_failsafe_timer_n, 1);
    chk("strb_on", valid_command_strobe_n, 0);
    tk(4); cmd_done <= 1;
    #1 chk("strb_hold", valid_command_strobe_n, 0);
    tk(1); cmd_done <= 0;
    #1 chk("strb_off", valid_command_strobe_n, 1);
    $display("timer test done");
  endtask
  // Fail flag, channel indicator, biphase pins
  task automatic t_misc;
    chk("tx_idle", {tx_chan_a_true, tx_chan_a_comp, tx_chan_b_true,
        tx_chan_b_comp}, 0);
    tk(1); bit_fail <= 1; tx_en <= 2'b01; tx_bit <= 2'b01;
    chan_act <= 1; rx_chan_a_comp <= 1; rx_chan_b_true <= 1;
    tk(1); chan_act <= 0;
    tk(4); #1 chk("fail", {self_test_fail, terminal_flag}, 2'b11);
    chk("chan_b", channel_indicator, 0);
    chk("tx_one", {tx_chan_a_true, tx_chan_a_comp, tx_chan_b_true,
        tx_chan_b_comp}, 4'b1000);
    chk("rx", rx_pairs, 4'b0110);
    tk(1); tx_bit <= 0; rt_mode <= 0; bit_fail <= 0;
    tk(2); #1 chk("tx_zero", {tx_chan_a_true, tx_chan_a_comp,
        tx_chan_b_true, tx_chan_b_comp}, 4'b0100);
    chk("fail_off", {self_test_fail, terminal_flag}, 2'b00);
    $display("misc test done");
  endtask
  // One DMA cycle: request, grant, strobes per word, release
  task automatic t_dma(logic wr, logic [2:0] w, int n);
    int k, seen, bad;
    logic p, q;
    seen = 0;
    bad = 0;
    q = 1;
    tk(1); mem_need <= 1; mem_write <= wr; mem_words <= w;
    tk(2); mem_need <= 0;
    #1 chk("req", {mem_request_n, mem_busy}, 2'b01);
    for (k = 0; k < 400 && mem_done !== 1'b1; k++) begin
      tk(1); #1 p = wr ? ram_write_strobe_n : ram_read_strobe_n;
      if (!mem_request_n && !mem_acknowledge_n) bad |= 1;
      if (tristate_control_n !== mem_acknowledge_n) bad |= 2;
      if (!mem_acknowledge_n && burst !== (n >= 2)) bad |= 4;
      if (!p && mem_acknowledge_n) bad |= 8;
      if (!p && memory_clock_half !== 1'b1) bad |= 16;
      if ((wr ? ram_read_strobe_n : ram_write_strobe_n) !== 1'b1) bad |= 32;
      if (q === 1'b1 && p === 1'b0) seen++;
      q = p;
    end
    chk("dma_flags", bad, 0);
    chk("words", seen, n);
    chk("done", {mem_done, mem_acknowledge_n, host_drive, mem_busy},
        4'b1110);
    $display("dma test done");
  endtask
  // Unrequested grant reaches the grant output
  task automatic t_pass;
    int k;
    tk(1); stray <= 1;
    for (k = 0; k < 40 && grant_passthrough_n !== 1'b0; k++) begin
      tk(1); #1;
    end
    chk("pass_on", grant_passthrough_n, 0);
    tk(1); stray <= 0;
    tk(12); #1 chk("pass_off", grant_passthrough_n, 1);
    $display("grant out test done");
  endtask
  initial begin
    tk(4); rst <= 0;
    tk(2);
    t_irq;
    t_tmr;
    t_misc;
    t_dma(1'b0, 3'h3, 3);
    t_dma(1'b1, 3'h1, 1);
    t_dma(1'b0, 3'h6, 6);
    t_dma(1'b0, 3'h7, 6);
    t_dma(1'b1, 3'h0, 1);
    t_pass;
    summarize;
  end
endmodule
